// [hw/mcr_consts.vh]
// constants for the modem configuration register bank
// Notes on behaviour
// R1: two 8-bit identifier registers join into one 16-bit scramble identifier.
// R2: all units in a system must share the same scramble identifier.
// R3: out-of-range writes are rejected and raise the format reject response.
// R4: group select 01H, 02H, 03H picks one, two or three channels; others rejected.
// R5: channel registers accept codes 02H to 51H only.
// R6: first channel always active; second for group 2 or 3; third for 3.
// R7: host should not program duplicate channels when several are active.
// R8: without acknowledgement, retransmit up to retry count plus one times.
// R9: broadcast always sends exactly retry count plus one times.
// R10: policy bit 0 set suppresses every serial response to the host.
// R11: policy bits 1 and 2 act only while bit 0 enables responses.
// R12: bit 2 clear sends format reject on bad packet or 5 s byte gap.
// R13: bit 1 clear sends accepted, delivered and delivery-failed responses.
// R14: bit 1 set omits accepted; only delivered or delivery-failed remain.
// R15: in headerless mode 40H is a header only after gap over interval times 100 ms.
// R16: interval 00H makes every 40H byte a command header.
// R17: host should keep unused registers at defaults, 01H then 00H.
// R18: address filter bits 7 to 2 unused; bit 1 controls group address check.
// R19: mode F0H is packet mode, FFH headerless; interval check only headerless.
// R20: registers are 8 bits, keep last accepted value, rejected writes change nothing; here a rejected write still sets status bit 0.
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH
`define MCR_ADDR_MODE      5'h03
`define MCR_ADDR_ID_LOW    5'h04
`define MCR_ADDR_ID_HIGH   5'h05
`define MCR_ADDR_GROUP     5'h06
`define MCR_ADDR_CHAN1     5'h07
`define MCR_ADDR_CHAN2     5'h08
`define MCR_ADDR_CHAN3     5'h09
`define MCR_ADDR_SPARE1    5'h0a
`define MCR_ADDR_RETRY     5'h0b
`define MCR_ADDR_SPARE2    5'h0c
`define MCR_ADDR_POLICY    5'h0d
`define MCR_ADDR_SPARE3    5'h0e
`define MCR_ADDR_INTERVAL  5'h0f
`define MCR_ADDR_SPARE4    5'h10
`define MCR_ADDR_SPARE5    5'h11
`define MCR_ADDR_FILTER    5'h12
`define MCR_ADDR_STATUS    5'h1f
`define MCR_RST_MODE       8'hf0
`define MCR_RST_ID_LOW     8'h00
`define MCR_RST_ID_HIGH    8'h00
`define MCR_RST_GROUP      8'h03
`define MCR_RST_CHAN1      8'h02
`define MCR_RST_CHAN2      8'h2a
`define MCR_RST_CHAN3      8'h51
`define MCR_RST_SPARE1     8'h01
`define MCR_RST_RETRY      8'h0a
`define MCR_RST_SPARE      8'h00
`define MCR_RST_POLICY     8'h00
`define MCR_RST_INTERVAL   8'h00
`define MCR_RST_FILTER     8'h8d
`define MCR_MODE_PACKET    8'hf0
`define MCR_MODE_HEADLESS  8'hff
`define MCR_CHAN_MIN       8'h02
`define MCR_CHAN_MAX       8'h51
`define MCR_GROUP_MIN      8'h01
`define MCR_GROUP_MAX      8'h03
`define MCR_POLICY_MASK    8'h07
`define MCR_POL_SILENT     0
`define MCR_POL_NO_ACCEPT  1
`define MCR_POL_NO_REJECT  2
`define MCR_FILTER_GROUP   1
`define MCR_HEADER_BYTE    8'h40
`define MCR_CLOCK_HZ       50000000
`define MCR_GAP_UNIT_MS    100
`define MCR_IDLE_LIMIT_S   5
`define MCR_UNIT_CYCLES    ((`MCR_CLOCK_HZ / 1000) * `MCR_GAP_UNIT_MS)
`define MCR_IDLE_CYCLES    (`MCR_CLOCK_HZ * `MCR_IDLE_LIMIT_S)
`endif

// [hw/mcr_config_bank.v]
// modem configuration register bank with response gating and header qualification
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_config_bank #(
  parameter integer UNIT_CYCLES = `MCR_UNIT_CYCLES,
  parameter integer IDLE_CYCLES = `MCR_IDLE_CYCLES
) (
  input  wire        clock,
  input  wire        reset,
  input  wire [4:0]  regAddr,
  input  wire [7:0]  regWriteData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regReadData,
  input  wire        hostByteValid,
  input  wire [7:0]  hostByte,
  input  wire        hostPacketValid,
  input  wire        hostPacketBad,
  input  wire        sendStart,
  input  wire        sendBroadcast,
  input  wire        ackReceived,
  output reg         commandHeader,
  output reg         formatRejectResponse,
  output reg         acceptedResponse,
  output reg         deliveredResponse,
  output reg         deliveryFailedResponse,
  output reg         transmitPulse,
  output reg         sendBusy,
  output reg  [15:0] scrambleId,
  output reg  [1:0]  channelCount,
  output reg  [7:0]  channelFirst,
  output reg  [7:0]  channelSecond,
  output reg  [7:0]  channelThird,
  output reg         headerlessMode,
  output reg         groupCheckEnable
);

  // ---------------------------------------------------------------
  // range checks
  // ---------------------------------------------------------------
  function inRange;
    input [7:0] value;
    input [7:0] low;
    input [7:0] high;
    begin
      inRange = (value >= low) && (value <= high);
    end
  endfunction

  reg [7:0] modeReg;
  reg [7:0] idLowReg;
  reg [7:0] idHighReg;
  reg [7:0] groupReg;
  reg [7:0] chan1Reg;
  reg [7:0] chan2Reg;
  reg [7:0] chan3Reg;
  reg [7:0] spare1Reg;
  reg [7:0] retryReg;
  reg [7:0] spare2Reg;
  reg [7:0] policyReg;
  reg [7:0] spare3Reg;
  reg [7:0] intervalReg;
  reg [7:0] spare4Reg;
  reg [7:0] spare5Reg;
  reg [7:0] filterReg;
  reg       lastRejectReg;

  // ---------------------------------------------------------------
  // write validation
  // ---------------------------------------------------------------
  // unmapped indices, the status word among them, refuse every write
  reg writeOk;
  always @* begin
    writeOk = 1'b1;
    if (regAddr == `MCR_ADDR_MODE) begin
      writeOk = (regWriteData == `MCR_MODE_PACKET) || (regWriteData == `MCR_MODE_HEADLESS); // R19
    end else if (regAddr == `MCR_ADDR_GROUP) begin
      writeOk = inRange(regWriteData, `MCR_GROUP_MIN, `MCR_GROUP_MAX); // R4
    end else if ((regAddr == `MCR_ADDR_CHAN1) || (regAddr == `MCR_ADDR_CHAN2) ||
                 (regAddr == `MCR_ADDR_CHAN3)) begin
      writeOk = inRange(regWriteData, `MCR_CHAN_MIN, `MCR_CHAN_MAX); // R5
    end else if (regAddr == `MCR_ADDR_POLICY) begin
      writeOk = (regWriteData & ~`MCR_POLICY_MASK) == 8'h00;
    end else if ((regAddr >= `MCR_ADDR_ID_LOW) && (regAddr <= `MCR_ADDR_FILTER)) begin
      writeOk = 1'b1; // R1
    end else begin
      writeOk = 1'b0;
    end
  end

  wire writeAccept = regWrite && writeOk; // R20
  wire writeReject = regWrite && !writeOk; // R3
  wire responsesOn = !policyReg[`MCR_POL_SILENT]; // R10

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      modeReg <= `MCR_RST_MODE;
      idLowReg <= `MCR_RST_ID_LOW;
      idHighReg <= `MCR_RST_ID_HIGH;
      groupReg <= `MCR_RST_GROUP;
      chan1Reg <= `MCR_RST_CHAN1;
      chan2Reg <= `MCR_RST_CHAN2;
      chan3Reg <= `MCR_RST_CHAN3;
      spare1Reg <= `MCR_RST_SPARE1;
      retryReg <= `MCR_RST_RETRY;
      spare2Reg <= `MCR_RST_SPARE;
      policyReg <= `MCR_RST_POLICY;
      spare3Reg <= `MCR_RST_SPARE;
      intervalReg <= `MCR_RST_INTERVAL;
      spare4Reg <= `MCR_RST_SPARE;
      spare5Reg <= `MCR_RST_SPARE;
      filterReg <= `MCR_RST_FILTER;
      lastRejectReg <= 1'b0;
    end else begin
      if (writeAccept) begin // R20
        if (regAddr == `MCR_ADDR_MODE) begin
          modeReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_ID_LOW) begin
          idLowReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_ID_HIGH) begin
          idHighReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_GROUP) begin
          groupReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_CHAN1) begin
          chan1Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_CHAN2) begin
          chan2Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_CHAN3) begin
          chan3Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_SPARE1) begin
          spare1Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_RETRY) begin
          retryReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_SPARE2) begin
          spare2Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_POLICY) begin
          policyReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_SPARE3) begin
          spare3Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_INTERVAL) begin
          intervalReg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_SPARE4) begin
          spare4Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_SPARE5) begin
          spare5Reg <= regWriteData;
        end else if (regAddr == `MCR_ADDR_FILTER) begin
          filterReg <= regWriteData;
        end
      end
      if (regWrite) begin
        lastRejectReg <= writeReject;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  reg [7:0] readValue;
  always @* begin
    readValue = 8'h00;
    if (regAddr == `MCR_ADDR_MODE) begin
      readValue = modeReg;
    end else if (regAddr == `MCR_ADDR_ID_LOW) begin
      readValue = idLowReg;
    end else if (regAddr == `MCR_ADDR_ID_HIGH) begin
      readValue = idHighReg;
    end else if (regAddr == `MCR_ADDR_GROUP) begin
      readValue = groupReg;
    end else if (regAddr == `MCR_ADDR_CHAN1) begin
      readValue = chan1Reg;
    end else if (regAddr == `MCR_ADDR_CHAN2) begin
      readValue = chan2Reg;
    end else if (regAddr == `MCR_ADDR_CHAN3) begin
      readValue = chan3Reg;
    end else if (regAddr == `MCR_ADDR_SPARE1) begin
      readValue = spare1Reg;
    end else if (regAddr == `MCR_ADDR_RETRY) begin
      readValue = retryReg;
    end else if (regAddr == `MCR_ADDR_SPARE2) begin
      readValue = spare2Reg;
    end else if (regAddr == `MCR_ADDR_POLICY) begin
      readValue = policyReg;
    end else if (regAddr == `MCR_ADDR_SPARE3) begin
      readValue = spare3Reg;
    end else if (regAddr == `MCR_ADDR_INTERVAL) begin
      readValue = intervalReg;
    end else if (regAddr == `MCR_ADDR_SPARE4) begin
      readValue = spare4Reg;
    end else if (regAddr == `MCR_ADDR_SPARE5) begin
      readValue = spare5Reg;
    end else if (regAddr == `MCR_ADDR_FILTER) begin
      readValue = filterReg;
    end else if (regAddr == `MCR_ADDR_STATUS) begin
      readValue = {5'h00, sendBusy, headerlessMode, lastRejectReg};
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= readValue;
    end else begin
      regReadData <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // byte gap timing
  // ---------------------------------------------------------------
  reg [31:0] unitCount;
  reg [7:0]  gapUnits;
  reg        gapSaturated;
  reg [31:0] idleCount;
  reg        idleTimeout;
  reg        inPacket;

  // the gap is kept in whole units: a header needs interval plus one of them
  wire gapLong = gapSaturated || (gapUnits > intervalReg); // R15
  wire isHeader = hostByteValid && (hostByte == `MCR_HEADER_BYTE) &&
                  (!headerlessMode || (intervalReg == 8'h00) || gapLong); // R16 R19

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      unitCount <= 32'h0;
      gapUnits <= 8'h00;
      gapSaturated <= 1'b0;
      idleCount <= 32'h0;
      idleTimeout <= 1'b0;
      inPacket <= 1'b0;
    end else begin
      idleTimeout <= 1'b0;
      if (hostByteValid) begin
        unitCount <= 32'h0;
        gapUnits <= 8'h00;
        gapSaturated <= 1'b0;
        idleCount <= 32'h0;
        inPacket <= !hostPacketValid && !hostPacketBad;
      end else begin
        if (unitCount == UNIT_CYCLES - 1) begin
          unitCount <= 32'h0;
          if (gapUnits == 8'hff) begin
            gapSaturated <= 1'b1;
          end else begin
            gapUnits <= gapUnits + 8'h01;
          end
        end else begin
          unitCount <= unitCount + 32'h1;
        end
        // the idle limit runs only inside a packet; a quiet line between packets is fine
        if (hostPacketValid || hostPacketBad) begin
          inPacket <= 1'b0;
        end else if (inPacket && idleCount == IDLE_CYCLES - 1) begin
          idleTimeout <= 1'b1; // R12
          inPacket <= 1'b0;
        end else if (inPacket) begin
          idleCount <= idleCount + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // retransmission sequencer
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  reg [1:0] sendState;
  reg [8:0] sendsLeft;
  reg       broadcastReg;
  reg       sendDone;
  reg       sendOk;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sendState <= ST_IDLE;
      sendsLeft <= 9'h000;
      broadcastReg <= 1'b0;
      transmitPulse <= 1'b0;
      sendBusy <= 1'b0;
      sendDone <= 1'b0;
      sendOk <= 1'b0;
    end else begin
      transmitPulse <= 1'b0;
      sendDone <= 1'b0;
      case (sendState)
        ST_IDLE: begin
          if (sendStart) begin
            sendsLeft <= {1'b0, retryReg} + 9'h001; // R8 R9
            broadcastReg <= sendBroadcast;
            sendBusy <= 1'b1;
            sendState <= ST_SEND;
          end
        end
        ST_SEND: begin
          transmitPulse <= 1'b1;
          sendsLeft <= sendsLeft - 9'h001;
          sendState <= ST_WAIT;
        end
        // the acknowledgement is looked at only in the wait after each attempt
        default: begin
          if (ackReceived && !broadcastReg) begin
            sendDone <= 1'b1; // R8
            sendOk <= 1'b1;
            sendBusy <= 1'b0;
            sendState <= ST_IDLE;
          end else if (sendsLeft != 9'h000) begin
            sendState <= ST_SEND;
          end else begin
            sendDone <= 1'b1; // R9
            sendOk <= broadcastReg;
            sendBusy <= 1'b0;
            sendState <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // host responses
  // ---------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      commandHeader <= 1'b0;
      formatRejectResponse <= 1'b0;
      acceptedResponse <= 1'b0;
      deliveredResponse <= 1'b0;
      deliveryFailedResponse <= 1'b0;
    end else begin
      commandHeader <= isHeader;
      formatRejectResponse <= responsesOn && !policyReg[`MCR_POL_NO_REJECT] &&
                              (writeReject || hostPacketBad || idleTimeout); // R3 R11 R12
      acceptedResponse <= responsesOn && !policyReg[`MCR_POL_NO_ACCEPT] &&
                          hostPacketValid; // R13 R14
      deliveredResponse <= responsesOn && sendDone && sendOk; // R13
      deliveryFailedResponse <= responsesOn && sendDone && !sendOk; // R14
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      scrambleId <= {`MCR_RST_ID_HIGH, `MCR_RST_ID_LOW};
      channelCount <= 2'd3;
      channelFirst <= `MCR_RST_CHAN1;
      channelSecond <= `MCR_RST_CHAN2;
      channelThird <= `MCR_RST_CHAN3;
      headerlessMode <= 1'b0;
      groupCheckEnable <= 1'b0;
    end else begin
      scrambleId <= {idHighReg, idLowReg}; // R1
      channelCount <= groupReg[1:0]; // R4
      channelFirst <= chan1Reg; // R6
      channelSecond <= (groupReg[1:0] >= 2'd2) ? chan2Reg : 8'h00; // R6
      channelThird <= (groupReg[1:0] == 2'd3) ? chan3Reg : 8'h00; // R6
      headerlessMode <= (modeReg == `MCR_MODE_HEADLESS); // R19
      groupCheckEnable <= filterReg[`MCR_FILTER_GROUP]; // R18
    end
  end

endmodule
`default_nettype wire

// [dv/mcr_config_bank_sva.sv]
// assertions on the modem configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module mcr_config_bank_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [4:0]  regAddr,
  input wire logic [7:0]  regWriteData,
  input wire logic        regWrite,
  input wire logic        hostByteValid,
  input wire logic [7:0]  hostByte,
  input wire logic        hostPacketValid,
  input wire logic        sendStart,
  input wire logic        sendBusy,
  input wire logic        transmitPulse,
  input wire logic        commandHeader,
  input wire logic        formatRejectResponse,
  input wire logic        acceptedResponse,
  input wire logic        deliveredResponse,
  input wire logic        deliveryFailedResponse,
  input wire logic [15:0] scrambleId,
  input wire logic [1:0]  channelCount
);
  // ----------------------------------------
  // shadow of policy and gap interval writes
  // ----------------------------------------
  logic [7:0] policyReg;
  logic [7:0] gapReg;
  wire        silentBit = policyReg[0];
  wire        rejOn = !policyReg[0] && !policyReg[2];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      policyReg <= 8'h00;
      gapReg <= 8'h00;
    end else if (regWrite && regAddr == 5'h0d && regWriteData[7:3] == 5'h00) begin
      policyReg <= regWriteData;
    end else if (regWrite && regAddr == 5'h0f) begin
      gapReg <= regWriteData;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_chanReject;
    regWrite && regAddr == 5'h07 && regWriteData > 8'h51 && rejOn |=> formatRejectResponse;
  endproperty
  a_chanReject: assert property (p_chanReject) else $error("bad channel not rejected");
  property p_groupReject;
    regWrite && regAddr == 5'h06 && (regWriteData == 8'h00 || regWriteData > 8'h03) && rejOn
      |=> formatRejectResponse;
  endproperty
  a_groupReject: assert property (p_groupReject) else $error("bad group not rejected");
  property p_groupCount;
    regWrite && regAddr == 5'h06 && regWriteData inside {8'h01, 8'h02, 8'h03}
      |=> ##1 {6'h00, channelCount} == $past(regWriteData, 2);
  endproperty
  a_groupCount: assert property (p_groupCount) else $error("channel count wrong");
  property p_scramble;
    regWrite && regAddr == 5'h04 |=> ##1 scrambleId[7:0] == $past(regWriteData, 2);
  endproperty
  a_scramble: assert property (p_scramble) else $error("scramble low byte wrong");
  property p_silent;
    $past(silentBit) |-> !acceptedResponse && !formatRejectResponse && !deliveredResponse
      && !deliveryFailedResponse;
  endproperty
  a_silent: assert property (p_silent) else $error("response while silenced");
  property p_accept;
    hostPacketValid && policyReg[1:0] == 2'b00 |=> acceptedResponse;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted response missing");
  property p_noAccept;
    policyReg[1] |=> !acceptedResponse;
  endproperty
  a_noAccept: assert property (p_noAccept) else $error("accepted response not omitted");
  property p_noReject;
    policyReg[2] |=> !formatRejectResponse;
  endproperty
  a_noReject: assert property (p_noReject) else $error("reject response not disabled");
  property p_send;
    sendStart && !sendBusy |=> sendBusy ##1 transmitPulse;
  endproperty
  a_send: assert property (p_send) else $error("first attempt late");
  property p_header;
    hostByteValid && hostByte == 8'h40 && gapReg == 8'h00 |=> commandHeader;
  endproperty
  a_header: assert property (p_header) else $error("header byte missed");
  property p_noHeader;
    hostByteValid && hostByte != 8'h40 |=> !commandHeader;
  endproperty
  a_noHeader: assert property (p_noHeader) else $error("plain byte taken as header");
endmodule
`default_nettype wire

// [dv/mcr_host_model.sv]
// host side model: serial bytes, host packets and receiver acknowledgement
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
  input  wire logic       clock,
  input  wire logic       ackEnable,
  output var  logic       hostByteValid = 1'b0,
  output var  logic [7:0] hostByte = 8'h00,
  output var  logic       hostPacketValid = 1'b0,
  output var  logic       hostPacketBad = 1'b0,
  output wire logic       ackReceived
);
  assign ackReceived = ackEnable;
  task automatic sendByte(input logic [7:0] b);
    @(posedge clock);
    hostByteValid <= 1'b1;
    hostByte <= b;
    @(posedge clock);
    hostByteValid <= 1'b0;
    // released line shows the inverse, not a stale byte
    hostByte <= ~b;
  endtask
  task automatic sendPacket(input logic bad);
    @(posedge clock);
    hostPacketValid <= !bad;
    hostPacketBad <= bad;
    @(posedge clock);
    hostPacketValid <= 1'b0;
    hostPacketBad <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the modem configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic sendStart = 1'b0, sendBroadcast = 1'b0, ackEnable = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWriteData = 8'h00;
  wire [7:0] regReadData, hostByte, channelFirst, channelSecond, channelThird;
  wire hostByteValid, hostPacketValid, hostPacketBad, ackReceived, commandHeader;
  wire formatRejectResponse, acceptedResponse, deliveredResponse, deliveryFailedResponse;
  wire transmitPulse, sendBusy, headerlessMode, groupCheckEnable;
  wire [15:0] scrambleId;
  wire [1:0] channelCount;
  int failures = 0, tests_run = 0, cycles = 0;
  int rejCnt = 0, txCnt = 0, delCnt = 0, failCnt = 0, accCnt = 0, hdrCnt = 0, r0, a0, h0;
  logic [7:0] p;
  localparam logic [7:0] RST [16] = '{8'hf0, 8'h00, 8'h00, 8'h03, 8'h02, 8'h2a, 8'h51,
    8'h01, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8d};
  localparam logic [7:0] POL [4] = '{8'h00, 8'h02, 8'h01, 8'h04};
  mcr_config_bank #(.UNIT_CYCLES(10), .IDLE_CYCLES(50)) mcr_config_bank_inst (
    .clock(clock), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .hostByteValid(hostByteValid), .hostByte(hostByte), .hostPacketValid(hostPacketValid),
    .hostPacketBad(hostPacketBad), .sendStart(sendStart), .sendBroadcast(sendBroadcast),
    .ackReceived(ackReceived), .commandHeader(commandHeader),
    .formatRejectResponse(formatRejectResponse), .acceptedResponse(acceptedResponse),
    .deliveredResponse(deliveredResponse), .deliveryFailedResponse(deliveryFailedResponse),
    .transmitPulse(transmitPulse), .sendBusy(sendBusy), .scrambleId(scrambleId),
    .channelCount(channelCount), .channelFirst(channelFirst), .channelSecond(channelSecond),
    .channelThird(channelThird), .headerlessMode(headerlessMode),
    .groupCheckEnable(groupCheckEnable));
  mcr_host_model host (.clock(clock), .ackEnable(ackEnable), .hostByteValid(hostByteValid),
    .hostByte(hostByte), .hostPacketValid(hostPacketValid), .hostPacketBad(hostPacketBad),
    .ackReceived(ackReceived));
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    rejCnt += formatRejectResponse;
    txCnt += transmitPulse;
    delCnt += deliveredResponse;
    failCnt += deliveryFailedResponse;
    accCnt += acceptedResponse;
    hdrCnt += commandHeader;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic rej);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1 chk(formatRejectResponse, rej);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regReadData, e);
  endtask
  task automatic send(input logic bc, input logic ack, input int tx, input logic ok);
    int t0, d0, f0;
    t0 = txCnt;
    d0 = delCnt;
    f0 = failCnt;
    @(posedge clock);
    ackEnable <= ack;
    sendStart <= 1'b1;
    sendBroadcast <= bc;
    @(posedge clock);
    sendStart <= 1'b0;
    #1;
    for (int i = 0; i < 100 && sendBusy !== 1'b0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk(16'(txCnt - t0), 16'(tx));
    chk(16'(delCnt - d0), 16'(ok));
    chk(16'(failCnt - f0), 16'(!ok));
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // spare registers are only ever given their defaults
    for (int i = 0; i < 16; i++) rd(5'(i + 3), RST[i]);
    chk(groupCheckEnable, 1'b0);
    rd(5'h1e, 8'h00);
    wr(5'h1e, 8'h00, 1'b1);
    rd(5'h1f, 8'h01);
    wr(5'h0a, 8'h01, 1'b0);
    $display("reset test done");
    // distinct channels in every active slot
    for (int i = 0; i < 3; i++) begin
      wr(5'(7 + i), 8'h01, 1'b1);
      wr(5'(7 + i), 8'h52, 1'b1);
      wr(5'(7 + i), 8'(8'h10 * (i + 1)), 1'b0);
      rd(5'(7 + i), 8'(8'h10 * (i + 1)));
    end
    wr(5'h07, 8'h02, 1'b0);
    wr(5'h09, 8'h51, 1'b0);
    wr(5'h06, 8'h00, 1'b1);
    wr(5'h06, 8'h04, 1'b1);
    rd(5'h06, 8'h03);
    for (int g = 1; g < 4; g++) begin
      wr(5'h06, 8'(g), 1'b0);
      @(posedge clock);
      #1 chk(channelCount, 16'(g));
      chk(channelFirst, 8'h02);
      chk(channelSecond, g > 1 ? 8'h20 : 8'h00);
      chk(channelThird, g == 3 ? 8'h51 : 8'h00);
    end
    $display("channel test done");
    // identifier bytes join high then low; filter bit 1 enables the group check
    wr(5'h04, 8'ha5, 1'b0);
    wr(5'h05, 8'h3c, 1'b0);
    wr(5'h12, 8'h8f, 1'b0);
    @(posedge clock);
    #1 chk(scrambleId, 16'h3ca5);
    chk(groupCheckEnable, 1'b1);
    $display("identifier test done");
    for (int i = 0; i < 4; i++) begin
      p = POL[i];
      wr(5'h0d, p, 1'b0);
      r0 = rejCnt;
      a0 = accCnt;
      host.sendPacket(1'b0);
      host.sendPacket(1'b1);
      repeat (2) @(posedge clock);
      chk(16'(accCnt - a0), 16'(!p[0] && !p[1]));
      chk(16'(rejCnt - r0), 16'(!p[0] && !p[2]));
      wr(5'h06, 8'h04, !p[0] && !p[2]);
    end
    wr(5'h0d, 8'h00, 1'b0);
    wr(5'h0d, 8'h08, 1'b1);
    rd(5'h0d, 8'h00);
    $display("policy test done");
    wr(5'h0b, 8'h02, 1'b0);
    send(1'b0, 1'b0, 3, 1'b0);
    send(1'b0, 1'b1, 1, 1'b1);
    send(1'b1, 1'b1, 3, 1'b1);
    $display("send test done");
    wr(5'h03, 8'h12, 1'b1);
    wr(5'h03, 8'hff, 1'b0);
    @(posedge clock);
    #1 chk(headerlessMode, 1'b1);
    h0 = hdrCnt;
    host.sendByte(8'h40);
    host.sendByte(8'h41);
    host.sendByte(8'h40);
    repeat (2) @(posedge clock);
    chk(16'(hdrCnt - h0), 16'd2);
    wr(5'h0f, 8'h01, 1'b0);
    h0 = hdrCnt;
    host.sendByte(8'h40);
    repeat (25) @(posedge clock);
    host.sendByte(8'h40);
    repeat (2) @(posedge clock);
    chk(16'(hdrCnt - h0), 16'd1);
    r0 = rejCnt;
    host.sendByte(8'h41);
    repeat (60) @(posedge clock);
    chk(16'(rejCnt - r0), 16'd1);
    $display("header test done");
    end_sim();
  end
endmodule
bind mcr_config_bank mcr_config_bank_sva chk_inst (.clock(clock), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .hostByteValid(hostByteValid), .hostByte(hostByte), .hostPacketValid(hostPacketValid),
  .sendStart(sendStart), .sendBusy(sendBusy), .transmitPulse(transmitPulse),
  .commandHeader(commandHeader), .formatRejectResponse(formatRejectResponse),
  .acceptedResponse(acceptedResponse), .deliveredResponse(deliveredResponse),
  .deliveryFailedResponse(deliveryFailedResponse), .scrambleId(scrambleId),
  .channelCount(channelCount));
`default_nettype wire
